/* ssl_pkg.sv */
// Shared constants for the safety stop latch block
package ssl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] SSL_CTRL_ADDR = 8'h00;  // Input use control
    localparam logic [7:0] SSL_STAT_ADDR = 8'h04;  // Live state, read only
    localparam logic [7:0] SSL_ISTA_ADDR = 8'h08;  // Sticky events, write 1 clears
    localparam logic [7:0] SSL_IMSK_ADDR = 8'h0c;  // Interrupt enables

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SSL_CTRL_OK_USE    = 0;  // Healthy input is connected
    localparam int SSL_CTRL_FAULT_USE = 1;  // Fault input is connected
    localparam int SSL_STAT_HEALTHY   = 0;  // Latch is healthy
    localparam int SSL_STAT_OK_IN     = 1;  // Effective healthy input
    localparam int SSL_STAT_FAULT_IN  = 2;  // Effective fault input
    localparam int SSL_STAT_RESET_IN  = 3;  // Synchronised reset request
    localparam int SSL_EVT_TRIP       = 0;  // Entered faulted
    localparam int SSL_EVT_REARM      = 1;  // Entered healthy

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int         SSL_CTRL_W     = 2;      // Control field width
    localparam int         SSL_STAT_W     = 4;      // Status field width
    localparam int         SSL_EVT_W      = 2;      // Event field width
    localparam logic [1:0] SSL_CTRL_RST   = 2'h3;   // Both inputs in use
    localparam logic [1:0] SSL_EVT_RST    = 2'h0;   // No events pending
    localparam logic [1:0] SSL_IMSK_RST   = 2'h0;   // All masked

    // ------------------------------------------------------------
    // Latch states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSL_ST_FAULTED = 2'b01,
        SSL_ST_HEALTHY = 2'b10
    } ssl_state_t;

endpackage : ssl_pkg

/* ssl_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module ssl_sync #(
    parameter int              WIDTH = 3,     // Number of bits
    parameter logic [WIDTH-1:0] INIT = '0     // Level held during reset
) (
    input  wire logic             clk_i,      // Block clock
    input  wire logic             rst_n_i,    // Async reset, active low
    input  wire logic [WIDTH-1:0] async_i,    // Raw pin levels
    output logic      [WIDTH-1:0] sync_o      // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage
    logic [WIDTH-1:0] sync_q;  // Second stage

    // ------------------------------------------------------------
    // Two stages; metastability settles in the first
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= INIT;
            sync_q <= INIT;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : ssl_sync

/* ssl_top.sv */
// Safety stop latch with APB registers and event interrupt
// What this block does
// - One of two states, faulted after reset
// - Faulted: healthy low, fault high, heartbeat still
// - Healthy: healthy high, fault low
// - Recover on no fault, healthy, reset rise
// - Trip on fault high or healthy low
// - Unused inputs read non-fault; connect one
`timescale 1ns/100ps
module ssl_top
    import ssl_pkg::*;
(
    input  wire logic        MCLK_I,     // 25 MHz block clock
    input  wire logic        RST_N_I,    // Async reset, active low
    input  wire logic        OK_I,       // Healthy input pin
    input  wire logic        FAULT_I,    // Fault request pin
    input  wire logic        REARM_I,    // Reset request pin
    input  wire logic        PSEL,       // APB select
    input  wire logic        PENABLE,    // APB access phase
    input  wire logic        PWRITE,     // APB direction
    input  wire logic [7:0]  PADDR,      // APB byte address
    input  wire logic [31:0] PWDATA,     // APB write data
    output logic      [31:0] PRDATA,     // APB read data
    output logic             PREADY,     // APB ready
    output logic             PSLVERR,    // APB error, unmapped address
    output logic             OK_O,       // Healthy output
    output logic             FAULT_O,    // Fault indicator
    output logic             HEARTBEAT_O,// Toggles while healthy
    output logic             IRQ_O       // Level interrupt
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [2:0] pins_s;      // {rearm, fault, ok} after two flops
    logic       ok_s;        // Synchronised healthy pin
    logic       fault_s;     // Synchronised fault pin
    logic       rearm_s;     // Synchronised reset request

    // Reset levels are the non-fault values so no edge is faked
    ssl_sync #(
        .WIDTH (3),
        .INIT  (3'h1)
    ) u_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RST_N_I),
        .async_i ({REARM_I, FAULT_I, OK_I}),
        .sync_o  (pins_s)
    );

    assign ok_s    = pins_s[0];
    assign fault_s = pins_s[1];
    assign rearm_s = pins_s[2];

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ssl_state_t          state_q, state_d;    // Latch state
    logic                rearm_prev_q;        // Last cycle's reset request
    logic                rearm_prev_d;
    logic                hb_q, hb_d;          // Heartbeat level
    logic                ok_out_q, ok_out_d;  // Healthy output
    logic                flt_out_q, flt_out_d;// Fault output
    logic [SSL_CTRL_W-1:0] ctrl_q, ctrl_d;    // Input use bits
    logic [SSL_EVT_W-1:0]  ista_q, ista_d;    // Sticky events
    logic [SSL_EVT_W-1:0]  imsk_q, imsk_d;    // Event mask
    logic                irq_q, irq_d;        // Interrupt level
    logic [31:0]         rdata_q, rdata_d;    // Read data
    logic                ready_q, ready_d;    // Ready in access phase
    logic                err_q, err_d;        // Error in access phase
    logic                ok_eff;              // Healthy after use mask
    logic                fault_eff;           // Fault after use mask
    logic                rearm_edge;          // Reset request rose
    logic                trip;                // Trip condition
    logic [SSL_EVT_W-1:0] evt;                // Events this cycle
    logic                wr_en;               // Write completes now
    logic [SSL_STAT_W-1:0] stat;              // Live status word
    logic                mapped;              // Address decodes

    // ------------------------------------------------------------
    // Input qualification and edge detect
    // ------------------------------------------------------------
    // A disabled input takes its non-fault level, like a floating pin
    always_comb
    begin
        ok_eff       = ok_s | ~ctrl_q[SSL_CTRL_OK_USE];
        fault_eff    = fault_s & ctrl_q[SSL_CTRL_FAULT_USE];
        rearm_edge   = rearm_s & ~rearm_prev_q;
        rearm_prev_d = rearm_s;
        trip         = fault_eff | ~ok_eff;
    end

    // ------------------------------------------------------------
    // Latch state and outputs
    // ------------------------------------------------------------
    // Outputs follow the next state so they line up with state_q
    always_comb
    begin
        state_d = state_q;
        evt     = '0;
        unique case (state_q)
            SSL_ST_FAULTED:
            begin
                // Trip check first, so faults win over recovery
                if (!trip && rearm_edge)
                begin
                    state_d            = SSL_ST_HEALTHY;
                    evt[SSL_EVT_REARM] = 1'b1;
                end
            end
            SSL_ST_HEALTHY:
            begin
                if (trip)
                begin
                    state_d           = SSL_ST_FAULTED;
                    evt[SSL_EVT_TRIP] = 1'b1;
                end
            end
            default:
            begin
                // Illegal code: fail safe
                state_d = SSL_ST_FAULTED;
            end
        endcase
        ok_out_d  = (state_d == SSL_ST_HEALTHY);
        flt_out_d = (state_d != SSL_ST_HEALTHY);
        hb_d      = (state_d == SSL_ST_HEALTHY) ? ~hb_q : hb_q;
    end

    // Registered latch state; faulted out of reset
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_q      <= SSL_ST_FAULTED;
            rearm_prev_q <= 1'b0;
            hb_q         <= 1'b0;
            ok_out_q     <= 1'b0;
            flt_out_q    <= 1'b1;
        end
        else
        begin
            state_q      <= state_d;
            rearm_prev_q <= rearm_prev_d;
            hb_q         <= hb_d;
            ok_out_q     <= ok_out_d;
            flt_out_q    <= flt_out_d;
        end
    end

    // ------------------------------------------------------------
    // APB slave and registers
    // ------------------------------------------------------------
    // Answer decided in setup; access phase always lasts one cycle
    always_comb
    begin
        stat                   = '0;
        stat[SSL_STAT_HEALTHY] = (state_q == SSL_ST_HEALTHY);
        stat[SSL_STAT_OK_IN]   = ok_eff;
        stat[SSL_STAT_FAULT_IN]= fault_eff;
        stat[SSL_STAT_RESET_IN]= rearm_s;
        mapped  = (PADDR == SSL_CTRL_ADDR) || (PADDR == SSL_STAT_ADDR) ||
                  (PADDR == SSL_ISTA_ADDR) || (PADDR == SSL_IMSK_ADDR);
        wr_en   = PSEL & PENABLE & ready_q & PWRITE & ~err_q;
        ready_d = PSEL & ~PENABLE;
        err_d   = PSEL & ~PENABLE & ~mapped;
        rdata_d = rdata_q;
        if (PSEL && !PENABLE)
        begin
            // Unmapped and write cycles read zero
            rdata_d = '0;
            if (!PWRITE)
            begin
                unique case (PADDR)
                    SSL_CTRL_ADDR: rdata_d[SSL_CTRL_W-1:0] = ctrl_q;
                    SSL_STAT_ADDR: rdata_d[SSL_STAT_W-1:0] = stat;
                    SSL_ISTA_ADDR: rdata_d[SSL_EVT_W-1:0]  = ista_q;
                    SSL_IMSK_ADDR: rdata_d[SSL_EVT_W-1:0]  = imsk_q;
                    default:       rdata_d                 = '0;
                endcase
            end
        end
        ctrl_d = ctrl_q;
        imsk_d = imsk_q;
        ista_d = ista_q;
        if (wr_en && PADDR == SSL_CTRL_ADDR)
        begin
            ctrl_d = PWDATA[SSL_CTRL_W-1:0];
        end
        if (wr_en && PADDR == SSL_IMSK_ADDR)
        begin
            imsk_d = PWDATA[SSL_EVT_W-1:0];
        end
        if (wr_en && PADDR == SSL_ISTA_ADDR)
        begin
            ista_d = ista_q & ~PWDATA[SSL_EVT_W-1:0];
        end
        // New events win over a clear in the same cycle
        ista_d = ista_d | evt;
        irq_d  = |(ista_d & imsk_d);
    end

    // Register bank and bus answer flops
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ctrl_q  <= SSL_CTRL_RST;
            ista_q  <= SSL_EVT_RST;
            imsk_q  <= SSL_IMSK_RST;
            irq_q   <= 1'b0;
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            ista_q  <= ista_d;
            imsk_q  <= imsk_d;
            irq_q   <= irq_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign OK_O        = ok_out_q;
    assign FAULT_O     = flt_out_q;
    assign HEARTBEAT_O = hb_q;
    assign IRQ_O       = irq_q;
    assign PRDATA      = rdata_q;
    assign PREADY      = ready_q;
    assign PSLVERR     = err_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_state_legal: assert property (
        state_q inside {SSL_ST_FAULTED, SSL_ST_HEALTHY})
        else $error("Latch state code is illegal");

    a_faulted_outs: assert property (
        (state_q == SSL_ST_FAULTED) |-> (!OK_O && FAULT_O))
        else $error("Faulted outputs wrong");

    a_faulted_hb_still: assert property (
        (state_q == SSL_ST_FAULTED) ##1 (state_q == SSL_ST_FAULTED)
        |-> $stable(HEARTBEAT_O))
        else $error("Heartbeat moved while faulted");

    a_healthy_outs: assert property (
        (state_q == SSL_ST_HEALTHY) |-> (OK_O && !FAULT_O))
        else $error("Healthy outputs wrong");

    a_healthy_hb_toggle: assert property (
        (state_q == SSL_ST_HEALTHY) [*2] |-> $changed(HEARTBEAT_O))
        else $error("Heartbeat stuck while healthy");

    a_recover_cause: assert property (
        (state_q == SSL_ST_FAULTED) ##1 (state_q == SSL_ST_HEALTHY)
        |-> $past(rearm_edge) && $past(ok_eff) && !$past(fault_eff))
        else $error("Recovery without all conditions");

    // A one-cycle fault followed by a rearm edge may legally recover
    // two cycles later, so only the cycle after the trip is pinned
    a_trip_next: assert property (
        (state_q == SSL_ST_HEALTHY && trip) |=>
        (state_q == SSL_ST_FAULTED && !OK_O && FAULT_O))
        else $error("Trip not taken in one cycle");

    a_unused_safe: assert property (
        (!ctrl_q[SSL_CTRL_OK_USE] |-> ok_eff) and
        (!ctrl_q[SSL_CTRL_FAULT_USE] |-> !fault_eff))
        else $error("Unused input caused a fault");

    a_fault_priority: assert property (
        (state_q == SSL_ST_FAULTED && rearm_s && !$past(rearm_s) && trip)
        |=> (state_q == SSL_ST_FAULTED))
        else $error("Recovery beat a fault");

    // Without a fresh rising edge a faulted latch stays put
    a_rearm_edge_only: assert property (
        (state_q == SSL_ST_FAULTED && !rearm_edge)
        |=> (state_q == SSL_ST_FAULTED))
        else $error("Recovered without a rearm edge");

    // The trip event is recorded even if software clears it at once
    a_trip_event: assert property (
        (state_q == SSL_ST_HEALTHY && trip) |=> ista_q[SSL_EVT_TRIP])
        else $error("Trip event not recorded");

    c_recover: cover property (
        (state_q == SSL_ST_FAULTED) ##1 (state_q == SSL_ST_HEALTHY));
    c_trip: cover property (
        (state_q == SSL_ST_HEALTHY) ##1 (state_q == SSL_ST_FAULTED));
    c_irq: cover property ($rose(IRQ_O));
    c_clear_race: cover property (wr_en && PADDR == SSL_ISTA_ADDR && |evt);
    c_fault_wins: cover property (
        state_q == SSL_ST_FAULTED && rearm_edge && trip);

endmodule : ssl_top

/* ssl_far_model.sv */
// Far-side model: upstream fault pins and downstream heartbeat monitor
`timescale 1ns/100ps
module ssl_far_model (
    input  wire logic clk_i,              // Block clock
    input  wire logic ok_req_i,           // Wanted healthy level
    input  wire logic flt_req_i,          // Wanted fault level
    input  wire logic rearm_req_i,        // Wanted reset request level
    input  wire logic hb_i,               // Heartbeat from the latch
    output logic      ok_o      = 1'b1,   // Healthy pin
    output logic      flt_o     = 1'b0,   // Fault pin
    output logic      rearm_o   = 1'b0,   // Reset request pin
    output logic      alive_o             // Heartbeat moved last clock
);
    logic hb_q = 1'b0;                    // Heartbeat one clock ago

    // ------------------------------------------------------------
    // Upstream source: pins move just after an edge, like a clocked source
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        ok_o    <= ok_req_i;
        flt_o   <= flt_req_i;
        rearm_o <= rearm_req_i;
        hb_q    <= hb_i;
    end

    // Monitor only notices motion, so a stuck heartbeat reads as dead
    assign alive_o = hb_q ^ hb_i;
endmodule : ssl_far_model

/* testbench.sv */
// Self-checking testbench for the safety stop latch
`timescale 1ns/100ps
module testbench;
    import ssl_pkg::*;
    logic        mclk = 1'b0;             // 25 MHz block clock
    logic        rst_n = 1'b0;            // Reset, active low
    logic        psel = 1'b0;             // APB select
    logic        penable = 1'b0;          // APB access phase
    logic        pwrite = 1'b0;           // APB direction
    logic [7:0]  paddr = 8'h00;           // APB address
    logic [31:0] pwdata = 32'h0;          // APB write data
    logic [31:0] prdata;                  // APB read data
    logic        pready, pslverr;         // APB answer
    logic        ok_req = 1'b1;           // Wanted healthy pin
    logic        flt_req = 1'b0;          // Wanted fault pin
    logic        rearm_req = 1'b0;        // Wanted reset request pin
    logic        ok_pin, flt_pin, rearm_pin, alive;
    logic        ok_o, flt_o, hb_o, irq_o;
    int          n_errors = 0;            // Mismatches seen
    int          check_count = 0;         // Comparisons made

    // ------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------
    always #20 mclk = ~mclk;
    ssl_top uut (.MCLK_I(mclk), .RST_N_I(rst_n), .OK_I(ok_pin), .FAULT_I(flt_pin), .REARM_I(rearm_pin),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .OK_O(ok_o), .FAULT_O(flt_o), .HEARTBEAT_O(hb_o), .IRQ_O(irq_o));
    ssl_far_model far (.clk_i(mclk), .ok_req_i(ok_req), .flt_req_i(flt_req), .rearm_req_i(rearm_req),
        .hb_i(hb_o), .ok_o(ok_pin), .flt_o(flt_pin), .rearm_o(rearm_pin), .alive_o(alive));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: no APB answer", $time);
            give_verdict();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // Read a register and compare value and error flag
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp, "read data");
        check({31'h0, err}, {31'h0, exp_err}, "slave error");
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    // Outputs of both states are complementary
    task automatic st(input logic exp, input string what);
        check({31'h0, ok_o}, {31'h0, exp}, what);
        check({31'h0, flt_o}, {31'h0, ~exp}, what);
    endtask : st

    task automatic hb_check(input logic toggling);
        repeat (3)
        begin
            @(posedge mclk);
            check({31'h0, alive}, {31'h0, toggling}, "heartbeat motion");
        end
    endtask : hb_check

    // Fresh low-to-high request, long enough to pass the synchroniser
    task automatic pulse_rearm();
        rearm_req <= 1'b0;
        repeat (4) @(posedge mclk);
        rearm_req <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask : pulse_rearm

    task automatic wait_trip();
        int n;
        for (n = 0; n < 10 && ok_o !== 1'b0; n++)
            @(posedge mclk);
        if (ok_o !== 1'b0)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: latch never tripped", $time);
            give_verdict();
        end
    endtask : wait_trip

    // Unused inputs behave as non-fault levels
    function automatic logic exp_healthy(input logic o, input logic f, input logic [1:0] u);
        return (o | ~u[SSL_CTRL_OK_USE]) & ~(f & u[SSL_CTRL_FAULT_USE]);
    endfunction : exp_healthy

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [1:0] use_b;
        logic       o;
        logic       f;
        void'($urandom(32'h5ffa0e04));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        st(1'b0, "power-up state");
        hb_check(1'b0);
        rd_chk(SSL_CTRL_ADDR, {30'h0, SSL_CTRL_RST}, 1'b0);
        rd_chk(SSL_ISTA_ADDR, {30'h0, SSL_EVT_RST}, 1'b0);
        rd_chk(SSL_IMSK_ADDR, {30'h0, SSL_IMSK_RST}, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        $display("test reset done");
        wr(SSL_ISTA_ADDR, 32'h3);
        wr(SSL_IMSK_ADDR, 32'h3);
        pulse_rearm();
        st(1'b1, "rearmed");
        hb_check(1'b1);
        check({31'h0, irq_o}, 32'h1, "irq on rearm event");
        rd_chk(SSL_ISTA_ADDR, 32'h2, 1'b0);
        wr(SSL_ISTA_ADDR, 32'h2);
        repeat (2) @(posedge mclk);
        check({31'h0, irq_o}, 32'h0, "irq cleared");
        wr(SSL_IMSK_ADDR, 32'h0);
        $display("test rearm done");
        flt_req <= 1'b1;
        wait_trip();
        st(1'b0, "tripped by fault");
        hb_check(1'b0);
        check({31'h0, irq_o}, 32'h0, "masked trip");
        rd_chk(SSL_ISTA_ADDR, 32'h1, 1'b0);
        pulse_rearm();
        st(1'b0, "fault beats rearm");
        flt_req <= 1'b0;
        repeat (8) @(posedge mclk);
        st(1'b0, "held request ignored");
        pulse_rearm();
        st(1'b1, "rearm after fault gone");
        ok_req <= 1'b0;
        wait_trip();
        ok_req <= 1'b1;
        wr(SSL_STAT_ADDR, 32'hffffffff);
        // Faulted, healthy pin back, reset request still held high
        rd_chk(SSL_STAT_ADDR, 32'ha, 1'b0);
        $display("test trip done");
        repeat (24)
        begin
            // At least one input stays connected, as the far side must
            use_b = 2'($urandom_range(3, 1));
            o = 1'($urandom);
            f = 1'($urandom);
            wr(SSL_CTRL_ADDR, {30'h0, use_b});
            ok_req  <= o;
            flt_req <= f;
            pulse_rearm();
            st(exp_healthy(o, f, use_b), "random pins");
        end
        $display("test random done");
        give_verdict();
    end
endmodule : testbench
